//--- quad_port_pkg.sv
// Shared constants and types of the quad channel parallel host port
package quad_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_CHAN = 4;
  localparam int CHAN_W = 2;
  localparam int CNT_W = 4;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [CHAN_W-1:0] chan_t;
  typedef logic [NUM_CHAN-1:0] chan_vec_t;
  typedef logic [CNT_W-1:0] cnt_t;

  ////////////////////////////////////////////////////////////////////////////
  // Bus style select levels
  localparam logic STYLE_SEPARATE = 1'b1;
  localparam logic STYLE_COMBINED = 1'b0;

  // Direction line levels in combined style
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and idle values
  localparam data_t DATA_RESET = 8'h00;
  localparam data_t DATA_IDLE = 8'hFF;
  localparam chan_vec_t SEL_IDLE_N = 4'hF;
  localparam chan_vec_t IRQ_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Host strobe timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_MIN_NS = 50;
  localparam int STROBE_MIN_NS = 200;
  localparam int HOLD_MIN_NS = 50;
  localparam int SETUP_CYCLES = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam cnt_t SETUP_LOAD = cnt_t'(SETUP_CYCLES - 1);
  localparam cnt_t STROBE_LOAD = cnt_t'(STROBE_CYCLES - 1);
  localparam cnt_t HOLD_LOAD = cnt_t'(HOLD_CYCLES - 1);

endpackage

//--- quad_bus_if.sv
// Pin bundle between host processor and quad channel device
`timescale 1ns/10ps
interface quad_bus_if;
  import quad_port_pkg::*;

  // Mode strap and strobes
  logic bus_style_sel;
  logic read_strobe_n;
  logic write_strobe_n;
  logic channel_a_select_n;
  logic channel_b_select_n;
  logic channel_c_select_n;
  logic channel_d_select_n;
  addr_t addr;

  // Data bus drivers and resolved level
  data_t host_data_out;
  logic host_data_oe;
  data_t dev_data_out;
  logic dev_data_oe;
  data_t data_bus;

  // Interrupt pin drivers and resolved levels
  chan_vec_t int_out;
  chan_vec_t int_oe;
  chan_vec_t int_level;

  // Undriven data floats high; channel A pulls up only in combined style
  assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : DATA_IDLE);
  assign int_level = (int_oe & int_out) | (~int_oe & {3'b000, ~bus_style_sel});

  modport dev (
    input bus_style_sel, read_strobe_n, write_strobe_n, addr, data_bus,
    input channel_a_select_n, channel_b_select_n, channel_c_select_n, channel_d_select_n,
    output dev_data_out, dev_data_oe, int_out, int_oe
  );

  modport host (
    output bus_style_sel, read_strobe_n, write_strobe_n, addr, host_data_out, host_data_oe,
    output channel_a_select_n, channel_b_select_n, channel_c_select_n, channel_d_select_n,
    input data_bus, int_level
  );
endinterface

//--- quad_port_device.sv
// Device end of the quad channel parallel host port
`timescale 1ns/10ps
//
// Notes on behaviour
// R1: Style pin high separate strobes, low combined
// R2: Read strobe fall fetches register, drives data
// R3: Write strobe fall opens, rise stores data
// R4: Combined style: read strobe ignored, held high
// R5: Combined style: write strobe high read, low write
// R6: Separate style: each select enables its channel
// R7: Combined style: channel A select selects device
// R8: Combined style: B, C selects are channel address
// R9: Combined style: channel D select tied high
// R10: Separate style: enable bit drives interrupt pin
// R11: Combined style: channel A pin open-drain interrupt
// R12: Combined style: B, C, D pins held low
// R13: Three address lines pick one of eight
// R14: Eight-bit data bus, driven only on reads
// R15: Separate style: force select drives interrupt pins regardless
// R16: Shared interrupt low while any channel pending
module quad_port_device (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host bus pins
  quad_bus_if.dev BUS,
  // Register access toward the channels
  output logic REG_RD,
  output logic REG_WR,
  output quad_port_pkg::chan_t REG_CHAN,
  output quad_port_pkg::addr_t REG_ADDR,
  output quad_port_pkg::data_t REG_WDATA,
  input wire quad_port_pkg::data_t REG_RDATA,
  // Channel interrupt sources and enables
  input wire quad_port_pkg::chan_vec_t CHAN_IRQ,
  input wire quad_port_pkg::chan_vec_t CHAN_IRQ_EN,
  input wire logic INTERRUPT_FORCE_SELECT,
  // Status
  output logic SEL_CONFLICT
);
  import quad_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic style;
    logic rd_prev;
    logic wr_prev;
    logic wr_open;
    logic rd_pulse;
    logic wr_pulse;
    logic conflict;
    chan_t chan;
    addr_t addr;
    data_t wdata;
    data_t data_out;
    logic data_oe;
    chan_vec_t int_out;
    chan_vec_t int_oe;
  } dev_state_t;

  dev_state_t state_q;
  dev_state_t state_d;

  logic sep;
  logic sel_ok;
  logic sel_many;
  logic rd_act;
  logic wr_act;
  chan_t chan_now;
  chan_vec_t sel_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // True when exactly one select is active
  function automatic logic one_active(input chan_vec_t s);
    logic r;
    r = 1'b0;
    unique case (s)
      4'h1, 4'h2, 4'h4, 4'h8: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Channel number of a single active select
  function automatic chan_t sel_index(input chan_vec_t s);
    chan_t r;
    r = 2'h0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (s[i]) begin
        r = chan_t'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access decode per bus style

  always_comb begin
    sep = (BUS.bus_style_sel == STYLE_SEPARATE); // see R1
    sel_vec = ~{BUS.channel_d_select_n, BUS.channel_c_select_n,
                BUS.channel_b_select_n, BUS.channel_a_select_n};
    sel_ok = one_active(sel_vec); // see R6
    sel_many = (sel_vec != 4'h0) && !sel_ok;
    if (sep) begin
      rd_act = !BUS.read_strobe_n && sel_ok; // see R2
      wr_act = !BUS.write_strobe_n && sel_ok; // see R3
      chan_now = sel_index(sel_vec); // see R6
    end else begin
      // Read strobe and channel D select play no part here
      rd_act = !BUS.channel_a_select_n && (BUS.write_strobe_n == DIR_READ); // see R5 R7 R4 R9
      wr_act = !BUS.channel_a_select_n && (BUS.write_strobe_n == DIR_WRITE); // see R5 R7
      chan_now = {BUS.channel_c_select_n, BUS.channel_b_select_n}; // see R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    state_d.style = sep;
    state_d.rd_prev = rd_act;
    state_d.wr_prev = wr_act;
    state_d.rd_pulse = 1'b0;
    state_d.wr_pulse = 1'b0;
    state_d.conflict = 1'b0;

    // Separate style, several selects while a strobe is low: access dropped and flagged every cycle
    if (sep && sel_many && ((!BUS.read_strobe_n && !state_q.rd_prev) ||
        (!BUS.write_strobe_n && !state_q.wr_prev))) begin
      state_d.conflict = 1'b1;
    end

    // Read start: latch channel and register, ask for the byte
    if (rd_act && !state_q.rd_prev) begin
      state_d.chan = chan_now;
      state_d.addr = BUS.addr; // see R13
      state_d.rd_pulse = 1'b1; // see R2
    end

    // Byte arrives the cycle after the request
    if (state_q.rd_pulse) begin
      state_d.data_out = REG_RDATA; // see R2
      state_d.data_oe = 1'b1; // see R14
    end

    // Bus released as soon as the read ends
    if (!rd_act) begin
      state_d.data_oe = 1'b0; // see R14
    end

    // Write start: latch target
    if (wr_act && !state_q.wr_prev) begin
      state_d.chan = chan_now;
      state_d.addr = BUS.addr; // see R13
      state_d.wr_open = 1'b1; // see R3
    end

    // Data tracked while the write is open, last value stored
    if (wr_act && state_q.wr_open) begin
      state_d.wdata = BUS.data_bus; // see R3
    end

    if (!wr_act && state_q.wr_prev && state_q.wr_open) begin
      state_d.wr_pulse = 1'b1; // see R3
      state_d.wr_open = 1'b0;
    end

    // Style change mid access aborts it
    if (sep != state_q.style) begin
      state_d.wr_open = 1'b0;
      state_d.wr_pulse = 1'b0;
      state_d.rd_pulse = 1'b0;
      state_d.data_oe = 1'b0;
    end

    // Interrupt pins
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (sep) begin
        state_d.int_out[i] = CHAN_IRQ[i];
        state_d.int_oe[i] = CHAN_IRQ_EN[i] || INTERRUPT_FORCE_SELECT; // see R10 R15
      end else if (i == 0) begin
        state_d.int_out[i] = 1'b0;
        state_d.int_oe[i] = |CHAN_IRQ; // see R11 R16
      end else begin
        state_d.int_out[i] = 1'b0;
        state_d.int_oe[i] = 1'b1; // see R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign REG_RD = state_q.rd_pulse;
  assign REG_WR = state_q.wr_pulse;
  assign REG_CHAN = state_q.chan;
  assign REG_ADDR = state_q.addr;
  assign REG_WDATA = state_q.wdata;
  assign SEL_CONFLICT = state_q.conflict;
  assign BUS.dev_data_out = state_q.data_out;
  assign BUS.dev_data_oe = state_q.data_oe;
  assign BUS.int_out = state_q.int_out;
  assign BUS.int_oe = state_q.int_oe;

endmodule

//--- quad_port_host.sv
// Host processor end of the quad channel parallel host port
`timescale 1ns/10ps
module quad_port_host (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host bus pins
  quad_bus_if.host BUS,
  // Bus style strap
  input wire logic BUS_STYLE,
  // Command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire quad_port_pkg::chan_t CMD_CHAN,
  input wire quad_port_pkg::addr_t CMD_ADDR,
  input wire quad_port_pkg::data_t CMD_WDATA,
  output logic CMD_READY,
  // Read answer
  output logic RSP_VALID,
  output quad_port_pkg::data_t RSP_RDATA,
  // Interrupt levels seen
  output quad_port_pkg::chan_vec_t IRQ_PENDING
);
  import quad_port_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_SETUP = 4'h2,
    H_STROBE = 4'h4,
    H_HOLD = 4'h8
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t fsm;
    cnt_t cnt;
    logic style;
    logic write;
    logic ready;
    logic rsp_valid;
    data_t rdata;
    chan_vec_t irq;
    logic rd_n;
    logic wr_n;
    chan_vec_t sel_n;
    addr_t addr;
    data_t wdata;
    logic data_oe;
  } host_state_t;

  host_state_t state_q;
  host_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    state_d.rsp_valid = 1'b0;
    if (state_q.style == STYLE_SEPARATE) begin
      state_d.irq = BUS.int_level;
    end else begin
      state_d.irq = {3'b000, ~BUS.int_level[0]}; // see R11 R16
    end
    unique case (state_q.fsm)
      H_IDLE: begin
        state_d.style = BUS_STYLE;
        // Ready one cycle after reset, lowered again by a take
        state_d.ready = 1'b1;
        if (CMD_VALID && state_q.ready) begin
          state_d.ready = 1'b0;
          state_d.write = CMD_WRITE;
          state_d.addr = CMD_ADDR;
          state_d.wdata = CMD_WDATA;
          state_d.data_oe = CMD_WRITE;
          state_d.rd_n = 1'b1; // see R4
          if (state_q.style == STYLE_SEPARATE) begin
            state_d.sel_n = ~(4'h1 << CMD_CHAN); // see R6
          end else begin
            state_d.sel_n = {1'b1, CMD_CHAN[1], CMD_CHAN[0], 1'b1}; // see R8 R9
            state_d.wr_n = CMD_WRITE ? DIR_WRITE : DIR_READ; // see R5
          end
          state_d.cnt = SETUP_LOAD;
          state_d.fsm = H_SETUP;
        end
      end
      H_SETUP: begin
        if (state_q.cnt == 4'h0) begin
          if (state_q.style == STYLE_SEPARATE) begin
            state_d.rd_n = state_q.write; // see R2
            state_d.wr_n = !state_q.write; // see R3
          end else begin
            state_d.sel_n[0] = 1'b0; // see R7
          end
          state_d.cnt = STROBE_LOAD;
          state_d.fsm = H_STROBE;
        end else begin
          state_d.cnt = state_q.cnt - 4'h1;
        end
      end
      H_STROBE: begin
        if (state_q.cnt == 4'h0) begin
          if (!state_q.write) begin
            state_d.rdata = BUS.data_bus; // see R2
          end
          if (state_q.style == STYLE_SEPARATE) begin
            state_d.rd_n = 1'b1;
            state_d.wr_n = 1'b1;
          end else begin
            state_d.sel_n[0] = 1'b1;
          end
          state_d.cnt = HOLD_LOAD;
          state_d.fsm = H_HOLD;
        end else begin
          state_d.cnt = state_q.cnt - 4'h1;
        end
      end
      H_HOLD: begin
        if (state_q.cnt == 4'h0) begin
          state_d.data_oe = 1'b0;
          state_d.sel_n = SEL_IDLE_N;
          state_d.wr_n = 1'b1;
          state_d.rsp_valid = !state_q.write;
          state_d.ready = 1'b1;
          state_d.fsm = H_IDLE;
        end else begin
          state_d.cnt = state_q.cnt - 4'h1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= '{fsm: H_IDLE, cnt: 4'h0, style: STYLE_SEPARATE, write: 1'b0,
                   ready: 1'b0, rsp_valid: 1'b0, rdata: DATA_RESET, irq: IRQ_RESET,
                   rd_n: 1'b1, wr_n: 1'b1, sel_n: SEL_IDLE_N, addr: 3'h0,
                   wdata: DATA_RESET, data_oe: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign CMD_READY = state_q.ready;
  assign RSP_VALID = state_q.rsp_valid;
  assign RSP_RDATA = state_q.rdata;
  assign IRQ_PENDING = state_q.irq;
  assign BUS.bus_style_sel = state_q.style;
  assign BUS.read_strobe_n = state_q.rd_n;
  assign BUS.write_strobe_n = state_q.wr_n;
  assign BUS.channel_a_select_n = state_q.sel_n[0];
  assign BUS.channel_b_select_n = state_q.sel_n[1];
  assign BUS.channel_c_select_n = state_q.sel_n[2];
  assign BUS.channel_d_select_n = state_q.sel_n[3];
  assign BUS.addr = state_q.addr;
  assign BUS.host_data_out = state_q.wdata;
  assign BUS.host_data_oe = state_q.data_oe;

endmodule

//--- quad_port_monitor.sv
// Concurrent checks on the pins joining host and device ends
`timescale 1ns/10ps
module quad_port_monitor (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host driven pins
  input wire logic bus_style_sel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic channel_a_select_n,
  input wire logic channel_d_select_n,
  input wire quad_port_pkg::addr_t addr,
  input wire quad_port_pkg::data_t data_bus,
  // Device driven pins
  input wire logic dev_data_oe,
  input wire quad_port_pkg::chan_vec_t int_out,
  input wire quad_port_pkg::chan_vec_t int_oe
);
  import quad_port_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  style_pair_a: assert property (bus_style_sel |-> read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  read_width_a: assert property (
    bus_style_sel && $fell(read_strobe_n) |-> !read_strobe_n [*4] ##1 read_strobe_n)
    else $error("read strobe width wrong");
  read_drive_a: assert property (
    bus_style_sel && $fell(read_strobe_n) |-> ##[1:3] dev_data_oe)
    else $error("read data not driven");
  write_hold_a: assert property (
    bus_style_sel && !write_strobe_n |-> $stable(data_bus) && $stable(addr))
    else $error("write data moved under strobe");
  combined_idle_a: assert property (
    !bus_style_sel |-> read_strobe_n && channel_d_select_n)
    else $error("unused pins not high");
  dir_stable_a: assert property (
    !bus_style_sel && !channel_a_select_n |-> $stable(write_strobe_n) && $stable(addr))
    else $error("direction moved under select");
  wr_no_drive_a: assert property (
    !bus_style_sel && !write_strobe_n && !channel_a_select_n |-> !dev_data_oe)
    else $error("device drove bus on write");
  rd_only_a: assert property ($rose(dev_data_oe) |->
    (bus_style_sel ? !read_strobe_n : !channel_a_select_n && write_strobe_n))
    else $error("device drove bus outside read");
  od_pins_a: assert property (
    !bus_style_sel && $past(bus_style_sel) == 1'b0 |->
    !int_out[0] && int_oe[3:1] == 3'h7 && int_out[3:1] == 3'h0)
    else $error("combined interrupt pins wrong");
endmodule

//--- quad_uart_host_bus_port_tb.sv
// Self-checking bench joining host and device ends of the quad port
`timescale 1ns/10ps
module quad_uart_host_bus_port_tb;
  import quad_port_pkg::*;
  typedef struct packed {logic wr; chan_t ch; addr_t ad; data_t d;} note_t;
  logic clk_sys, rst, bus_style, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic reg_rd, reg_wr, force_sel, sel_conflict;
  chan_t cmd_chan, reg_chan;
  addr_t cmd_addr, reg_addr;
  data_t cmd_wdata, rsp_rdata, reg_wdata, reg_rdata;
  chan_vec_t irq_pending, chan_irq, chan_irq_en;
  note_t q[$];
  note_t nt;
  int num_errors = 0;
  int n_compared = 0;

  quad_bus_if quad_bus_if_inst ();
  quad_port_host quad_port_host_inst (.CLK_SYS(clk_sys), .RST(rst),
    .BUS(quad_bus_if_inst.host), .BUS_STYLE(bus_style), .CMD_VALID(cmd_valid),
    .CMD_WRITE(cmd_write), .CMD_CHAN(cmd_chan), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
    .IRQ_PENDING(irq_pending));
  quad_port_device quad_port_device_inst (.CLK_SYS(clk_sys), .RST(rst),
    .BUS(quad_bus_if_inst.dev), .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_CHAN(reg_chan),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CHAN_IRQ(chan_irq),
    .CHAN_IRQ_EN(chan_irq_en), .INTERRUPT_FORCE_SELECT(force_sel),
    .SEL_CONFLICT(sel_conflict));
  quad_port_monitor quad_port_monitor_inst (.CLK_SYS(clk_sys), .RST(rst),
    .bus_style_sel(quad_bus_if_inst.bus_style_sel),
    .read_strobe_n(quad_bus_if_inst.read_strobe_n),
    .write_strobe_n(quad_bus_if_inst.write_strobe_n),
    .channel_a_select_n(quad_bus_if_inst.channel_a_select_n),
    .channel_d_select_n(quad_bus_if_inst.channel_d_select_n),
    .addr(quad_bus_if_inst.addr), .data_bus(quad_bus_if_inst.data_bus),
    .dev_data_oe(quad_bus_if_inst.dev_data_oe), .int_out(quad_bus_if_inst.int_out),
    .int_oe(quad_bus_if_inst.int_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmd(input logic wr, input chan_t ch, input addr_t ad, input data_t d);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40);
    check("ready", 8'(cmd_ready), 8'h01);
    q.push_back('{wr, ch, ad, d});
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_chan <= ch;
    cmd_addr <= ad;
    cmd_wdata <= d;
    reg_rdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask

  task automatic irq_case(input logic sep);
    chan_vec_t irq, en;
    logic frc;
    irq = 4'($urandom());
    en = 4'($urandom());
    frc = sep & 1'($urandom());
    chan_irq <= irq;
    chan_irq_en <= en;
    force_sel <= frc;
    repeat (4) @(posedge clk_sys);
    check("irq", 8'(irq_pending), sep ? 8'(irq & (en | {4{frc}})) : {7'h00, |irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge clk_sys) begin
    // Host lowers one select only in separate style, the only style that flags a conflict, so no conflict may show
    if (rst === 1'b0 && sel_conflict !== 1'b0) check("conflict", 8'(sel_conflict), 8'h00);
    if (reg_rd === 1'b1 && q.size() > 0) begin
      check("read chan", 8'(reg_chan), 8'(q[0].ch));
      check("read addr", 8'(reg_addr), 8'(q[0].ad));
    end
    if (rsp_valid === 1'b1 || reg_wr === 1'b1) begin
      if (q.size() == 0) check("spare result", 8'h01, 8'h00);
      else begin
        nt = q.pop_front();
        check("kind", 8'(reg_wr), 8'(nt.wr));
        if (reg_wr === 1'b1) begin
          check("write chan", 8'(reg_chan), 8'(nt.ch));
          check("write addr", 8'(reg_addr), 8'(nt.ad));
          check("write data", reg_wdata, nt.d);
        end else check("read data", rsp_rdata, nt.d);
      end
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #300000;
    num_errors++;
    $display("Error watchdog expired");
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    bus_style = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_chan = 2'h0;
    cmd_addr = 3'h0;
    cmd_wdata = 8'h00;
    reg_rdata = 8'h00;
    chan_irq = 4'h0;
    chan_irq_en = 4'h0;
    force_sel = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    void'($urandom(92324));
    for (int s = 1; s >= 0; s--) begin
      bus_style <= s[0];
      repeat (4) @(posedge clk_sys);
      // Every channel and register, a write then a read of a fresh byte, back to back
      for (int i = 0; i < 32; i++) begin
        cmd(1'b1, chan_t'(i / 8), addr_t'(i), 8'($urandom()));
        cmd(1'b0, chan_t'(i / 8), addr_t'(i), 8'($urandom()));
      end
      repeat (8) irq_case(s[0]);
      $display("Style %0d test done", s);
    end
    repeat (10) @(posedge clk_sys);
    check("left notes", 8'(q.size()), 8'h00);
    end_of_test();
  end
endmodule
